/* tms_timer.sv */
// timer with compare, capture, toggle modulator and master serial port
//
// Chosen here: the register addresses and strobed register access.
`timescale 1ns/100ps
`include "tms_defs.svh"

// How it works
// R1 - toggle output inverts on stage clock edge
// R2 - preset loads toggle only when timer stopped
// R3 - eight bit frames, msb first
// R4 - master, shift clock half stage clock
// R5 - data out on sdo, in on sdi
// R6 - frame start loads tx buffer, shifts both
// R7 - full frame moves to rx buffer
// R8 - unread byte overwritten by next frame
// R9 - serial enable gates transfer; polarity selects idle clock level
// R10 - flags tx empty, rx full, tx done
// R11 - software writes next byte on flags
// R12 - data address writes tx, reads rx
// R13 - control a bit7 enables timer
// R14 - bit6 toggles output at enable
// R15 - bit5 selects capture source
// R16 - bit3 match resets counter; bit4 zero
// R17 - bit2 clears counter
// R18 - bit1 match toggles output
// R19 - bit0 overflow toggles output
// R20 - control b bit0 software capture, self clears
// R21 - capture read through shared high temp
// R22 - compare continuous, written through temp
// R23 - overflow at max or fixed top
// R24 - tx done when frame out, buffer empty
// R25 - disabled port holds idle clock level
module tms_timer #(
	parameter int WIDTH = 16
) (
	// clock and reset
	input  wire logic               clk_sys,
	input  wire logic               rst_n,
	// register port
	input  wire tms_pkg::tms_bus_req_t bus_req,
	output logic [7:0]              bus_rdata,
	// timer inputs
	input  wire logic               counter_input_clock,
	input  wire logic               capture_input_pin,
	input  wire logic               other_timer_out_clk,
	input  wire logic               sdi,
	// outputs
	output tms_pkg::tms_pins_t      pins,
	output logic                    counter_stage_out_clk,
	output logic [7:0]              irq_flags
);
	initial begin
		if (WIDTH != 16)
			$error("tms_timer: only a 16 bit counter is supported");
	end

	// =====================================================
	// registers
	logic [7:0]       ctrl_a_reg;
	logic             soft_cap_reg;
	logic [7:0]       mode_b_reg;
	logic [7:0]       mode_a_reg;
	logic [7:0]       mask_reg;
	logic [7:0]       temp_reg;
	logic [15:0]      cmp_reg;
	logic [15:0]      cap_reg;
	logic [15:0]      cnt_reg;
	logic [15:0]      cnt_next;
	logic             toggle_out_reg;
	logic             stage_clk_reg;
	logic             cap_src_reg;
	logic [7:0]       tx_buffer_reg;
	logic [7:0]       rx_buffer_reg;
	logic [7:0]       shift_register_reg;
	logic [2:0]       bit_cnt_reg;
	logic             tx_empty_reg;
	logic             rx_full_reg;
	logic             tx_done_reg;
	logic             cap_flag_reg;
	logic             cmp_flag_reg;
	logic             ovf_flag_reg;
	logic             cnt_clk_dly_reg;
	logic             sclk_reg;
	logic             sdo_reg;
	logic [7:0]       rdata_reg;
	tms_pkg::tms_ser_state_t ser_state_reg;

	// =====================================================
	// decode
	function automatic logic hit(input logic [3:0] a, input logic [3:0] o);
		hit = (a == o);
	endfunction : hit

	logic wr;
	logic rd;
	logic timer_on;
	logic ser_en;
	logic cpol;
	logic cnt_tick;
	logic [15:0] top_val;
	logic ovf_hit;
	logic cmp_hit;
	logic cap_sel;
	logic cap_evt;
	logic start_evt;
	logic stage_rise;
	logic frame_done;
	logic load_frame;

	assign wr       = bus_req.wr;
	assign rd       = bus_req.rd;
	assign timer_on = ctrl_a_reg[`TMS_A_ENABLE]; // R13
	assign ser_en   = mode_b_reg[`TMS_MB_SER_EN];
	assign cpol     = mode_b_reg[`TMS_MB_CPOL];
	assign cnt_tick = timer_on & counter_input_clock & ~cnt_clk_dly_reg;

	// =====================================================
	// counter
	always_comb begin
		case (mode_a_reg[`TMS_MA_TOP_HI:`TMS_MA_TOP_LO])
			2'h1:    top_val = `TMS_TOP_1; // R23
			2'h2:    top_val = `TMS_TOP_2;
			2'h3:    top_val = `TMS_TOP_3;
			default: top_val = `TMS_MAX;
		endcase
	end

	assign ovf_hit = cnt_tick & (cnt_reg == top_val); // R23
	assign cmp_hit = cnt_tick & (cnt_reg == cmp_reg); // R22
	assign cap_sel = ctrl_a_reg[`TMS_A_CAP_SRC] ? capture_input_pin
	                                            : other_timer_out_clk; // R15
	assign cap_evt = timer_on & cap_sel & ~cap_src_reg;
	assign start_evt = wr & hit(bus_req.addr, `TMS_OFS_CTRL_A)
	                 & bus_req.wdata[`TMS_A_ENABLE] & ~timer_on;

	always_comb begin
		cnt_next = cnt_reg;
		if (ovf_hit | (cmp_hit & ctrl_a_reg[`TMS_A_MATCH_RST])) // R16
			cnt_next = `TMS_RST_WORD;
		else if (cnt_tick)
			cnt_next = cnt_reg + 16'h0001;
		if (wr & hit(bus_req.addr, `TMS_OFS_CTRL_A)
		    & bus_req.wdata[`TMS_A_CLEAR])
			cnt_next = `TMS_RST_WORD; // R17
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			cnt_reg         <= `TMS_RST_WORD;
			cnt_clk_dly_reg <= 1'b0;
			cap_src_reg     <= 1'b0;
		end else begin
			cnt_reg         <= cnt_next;
			cnt_clk_dly_reg <= counter_input_clock;
			cap_src_reg     <= cap_sel;
		end
	end

	// stage output clock: one step per compare match or overflow
	always_ff @(posedge clk_sys) begin
		if (!rst_n)
			stage_clk_reg <= 1'b0;
		else if (cmp_hit | ovf_hit)
			stage_clk_reg <= ~stage_clk_reg;
	end
	assign stage_rise = (cmp_hit | ovf_hit) & ~stage_clk_reg;

	// =====================================================
	// toggle flip flop
	always_ff @(posedge clk_sys) begin
		if (!rst_n)
			toggle_out_reg <= 1'b0;
		else if (wr & hit(bus_req.addr, `TMS_OFS_MODE_B) & ~timer_on)
			toggle_out_reg <= bus_req.wdata[`TMS_MB_PRESET]; // R2
		else if (start_evt & bus_req.wdata[`TMS_A_TOG_START])
			toggle_out_reg <= ~toggle_out_reg; // R14
		else if ((cmp_hit & ctrl_a_reg[`TMS_A_MATCH_TOG]) // R18
		         ^ (ovf_hit & ctrl_a_reg[`TMS_A_OVF_TOG])) // R19
			toggle_out_reg <= ~toggle_out_reg; // R1
	end

	// =====================================================
	// capture
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			cap_reg      <= `TMS_RST_WORD;
			soft_cap_reg <= 1'b0;
		end else begin
			if (cap_evt | soft_cap_reg)
				cap_reg <= cnt_reg; // R21
			if (wr & hit(bus_req.addr, `TMS_OFS_CTRL_B)
			    & bus_req.wdata[`TMS_B_SOFT_CAP])
				soft_cap_reg <= 1'b1; // R20
			else if (soft_cap_reg)
				soft_cap_reg <= 1'b0; // R20
		end
	end

	// =====================================================
	// control registers and compare with shared temp
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			ctrl_a_reg <= `TMS_RST_BYTE;
			mode_b_reg <= `TMS_RST_BYTE;
			mode_a_reg <= `TMS_RST_BYTE;
			mask_reg   <= `TMS_RST_BYTE;
			temp_reg   <= `TMS_RST_BYTE;
			cmp_reg    <= `TMS_RST_WORD;
		end else if (wr) begin
			case (bus_req.addr)
				`TMS_OFS_CTRL_A: ctrl_a_reg <= bus_req.wdata
				                 & `TMS_A_RW_MASK
				                 & ~(8'h01 << `TMS_A_CLEAR); // R16
				`TMS_OFS_MODE_B: mode_b_reg <= bus_req.wdata
				                 & ~(8'h01 << `TMS_MB_PRESET);
				`TMS_OFS_MODE_A: mode_a_reg <= bus_req.wdata;
				`TMS_OFS_MASK:   mask_reg   <= bus_req.wdata & 8'h3f;
				`TMS_OFS_CMP_HI: temp_reg   <= bus_req.wdata; // R22
				`TMS_OFS_CMP_LO: cmp_reg    <= {temp_reg, bus_req.wdata}; // R22
				default: ;
			endcase
		end else if (rd & hit(bus_req.addr, `TMS_OFS_CAP_LO)) begin
			temp_reg <= cap_reg[15:8]; // R21
		end else if (rd & hit(bus_req.addr, `TMS_OFS_COUNT_LO)) begin
			temp_reg <= cnt_reg[15:8];
		end
	end

	// =====================================================
	// serial port
	assign load_frame = ser_en & ~tx_empty_reg
	                  & (ser_state_reg == tms_pkg::TMS_IDLE); // R6
	assign frame_done = stage_rise & (ser_state_reg == tms_pkg::TMS_SHIFT_HI)
	                  & (bit_cnt_reg == `TMS_BIT_CNT_LAST);
	logic data_wr;
	logic data_rd;
	assign data_wr = wr & hit(bus_req.addr, `TMS_OFS_DATA);
	assign data_rd = rd & hit(bus_req.addr, `TMS_OFS_DATA);

	always_ff @(posedge clk_sys) begin
		if (!rst_n || !ser_en) begin
			ser_state_reg      <= tms_pkg::TMS_IDLE; // R25
			shift_register_reg <= `TMS_RST_BYTE;
			bit_cnt_reg        <= 3'h0;
			sclk_reg           <= rst_n ? cpol : 1'b0; // R25
			sdo_reg            <= 1'b0;
		end else begin
			case (ser_state_reg)
				tms_pkg::TMS_IDLE: begin
					sclk_reg <= cpol; // R25
					if (load_frame) begin
						shift_register_reg <= tx_buffer_reg; // R6
						sdo_reg            <= tx_buffer_reg[7]; // R3
						bit_cnt_reg        <= 3'h0;
						ser_state_reg      <= tms_pkg::TMS_SHIFT_LO;
					end
				end
				tms_pkg::TMS_SHIFT_LO: if (stage_rise) begin
					sclk_reg      <= ~cpol; // R4
					ser_state_reg <= tms_pkg::TMS_SHIFT_HI;
				end
				tms_pkg::TMS_SHIFT_HI: if (stage_rise) begin
					sclk_reg <= cpol; // R4
					shift_register_reg <= {shift_register_reg[6:0], sdi}; // R5
					sdo_reg  <= shift_register_reg[6]; // R3
					bit_cnt_reg <= bit_cnt_reg + 3'h1;
					ser_state_reg <= (bit_cnt_reg == `TMS_BIT_CNT_LAST)
					                 ? tms_pkg::TMS_IDLE
					                 : tms_pkg::TMS_SHIFT_LO;
				end
				default: ser_state_reg <= tms_pkg::TMS_IDLE;
			endcase
		end
	end

	// buffers and flags; hardware set wins over software clear, except tx empty and tx done, where a data write wins
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			tx_buffer_reg <= `TMS_RST_BYTE;
			rx_buffer_reg <= `TMS_RST_BYTE;
			tx_empty_reg  <= 1'b1;
			rx_full_reg   <= 1'b0;
			tx_done_reg   <= 1'b0;
			cap_flag_reg  <= 1'b0;
			cmp_flag_reg  <= 1'b0;
			ovf_flag_reg  <= 1'b0;
		end else begin
			if (data_wr) begin
				tx_buffer_reg <= bus_req.wdata; // R12
				tx_empty_reg  <= 1'b0; // R10
			end else if (load_frame) begin
				tx_empty_reg  <= 1'b1; // R10
			end
			if (!ser_en)
				rx_full_reg <= 1'b0;
			else if (frame_done) begin
				rx_buffer_reg <= {shift_register_reg[6:0], sdi}; // R7 R8
				rx_full_reg   <= 1'b1; // R10
			end else if (data_rd)
				rx_full_reg <= 1'b0;
			if (frame_done & tx_empty_reg & ~data_wr)
				tx_done_reg <= 1'b1; // R24
			else if ((wr & hit(bus_req.addr, `TMS_OFS_FLAGS)
			          & bus_req.wdata[`TMS_F_TX_DONE]) | data_wr)
				tx_done_reg <= 1'b0; // R24
			if (cap_evt | soft_cap_reg)
				cap_flag_reg <= 1'b1;
			else if (wr & hit(bus_req.addr, `TMS_OFS_FLAGS)
			         & bus_req.wdata[`TMS_F_CAP])
				cap_flag_reg <= 1'b0;
			if (cmp_hit)
				cmp_flag_reg <= 1'b1;
			else if (wr & hit(bus_req.addr, `TMS_OFS_FLAGS)
			         & bus_req.wdata[`TMS_F_CMP])
				cmp_flag_reg <= 1'b0;
			if (ovf_hit)
				ovf_flag_reg <= 1'b1;
			else if (wr & hit(bus_req.addr, `TMS_OFS_FLAGS)
			         & bus_req.wdata[`TMS_F_OVF])
				ovf_flag_reg <= 1'b0;
		end
	end

	// =====================================================
	// read back
	logic [7:0] flags;
	assign flags = {2'b00, tx_done_reg, tx_empty_reg, rx_full_reg,
	                cap_flag_reg, cmp_flag_reg, ovf_flag_reg}; // R10

	always_ff @(posedge clk_sys) begin
		if (!rst_n)
			rdata_reg <= `TMS_RST_BYTE;
		else if (rd) begin
			case (bus_req.addr)
				`TMS_OFS_CTRL_A:   rdata_reg <= ctrl_a_reg; // R16
				`TMS_OFS_CTRL_B:   rdata_reg <= {7'h00, soft_cap_reg}; // R20
				`TMS_OFS_MODE_B:   rdata_reg <= mode_b_reg;
				`TMS_OFS_MODE_A:   rdata_reg <= mode_a_reg;
				`TMS_OFS_DATA:     rdata_reg <= rx_buffer_reg; // R12
				`TMS_OFS_CAP_LO:   rdata_reg <= cap_reg[7:0]; // R21
				`TMS_OFS_CAP_HI:   rdata_reg <= temp_reg; // R21
				`TMS_OFS_CMP_LO:   rdata_reg <= cmp_reg[7:0];
				`TMS_OFS_CMP_HI:   rdata_reg <= cmp_reg[15:8];
				`TMS_OFS_FLAGS:    rdata_reg <= flags;
				`TMS_OFS_MASK:     rdata_reg <= mask_reg;
				`TMS_OFS_COUNT_LO: rdata_reg <= cnt_reg[7:0];
				`TMS_OFS_COUNT_HI: rdata_reg <= temp_reg;
				default:           rdata_reg <= `TMS_RST_BYTE;
			endcase
		end else
			rdata_reg <= `TMS_RST_BYTE;
	end

	assign bus_rdata             = rdata_reg;
	assign irq_flags             = flags & mask_reg; // R10
	assign counter_stage_out_clk = stage_clk_reg;
	assign pins.sclk             = sclk_reg;
	assign pins.sdo              = sdo_reg; // R5
	assign pins.out_a            = toggle_out_reg;
	assign pins.out_b            = ~toggle_out_reg;
endmodule : tms_timer

/* tms_defs.svh */
// register offsets, field positions, reset values and fixed tops for the timer
`ifndef TMS_DEFS_SVH
`define TMS_DEFS_SVH
// register offsets
`define TMS_OFS_CTRL_A     4'h0
`define TMS_OFS_CTRL_B     4'h1
`define TMS_OFS_MODE_B     4'h2
`define TMS_OFS_DATA       4'h3
`define TMS_OFS_CAP_LO     4'h4
`define TMS_OFS_CAP_HI     4'h5
`define TMS_OFS_CMP_LO     4'h6
`define TMS_OFS_CMP_HI     4'h7
`define TMS_OFS_FLAGS      4'h8
`define TMS_OFS_MASK       4'h9
`define TMS_OFS_MODE_A     4'ha
`define TMS_OFS_COUNT_LO   4'hb
`define TMS_OFS_COUNT_HI   4'hc
// control a fields
`define TMS_A_ENABLE       7
`define TMS_A_TOG_START    6
`define TMS_A_CAP_SRC      5
`define TMS_A_MATCH_RST    3
`define TMS_A_CLEAR        2
`define TMS_A_MATCH_TOG    1
`define TMS_A_OVF_TOG      0
`define TMS_A_RW_MASK      8'hef
// control b field
`define TMS_B_SOFT_CAP     0
// mode b fields
`define TMS_MB_PRESET      2
`define TMS_MB_SER_EN      1
`define TMS_MB_CPOL        0
// mode a fields
`define TMS_MA_TOP_HI      7
`define TMS_MA_TOP_LO      6
// flag fields
`define TMS_F_TX_DONE      5
`define TMS_F_TX_EMPTY     4
`define TMS_F_RX_FULL      3
`define TMS_F_CAP          2
`define TMS_F_CMP          1
`define TMS_F_OVF          0
// values
`define TMS_MAX            16'hffff
`define TMS_TOP_1          16'h00ff
`define TMS_TOP_2          16'h01ff
`define TMS_TOP_3          16'h03ff
`define TMS_RST_BYTE       8'h00
`define TMS_RST_WORD       16'h0000
`define TMS_RST_FLAGS      8'h10
`define TMS_BIT_CNT_LAST   3'h7
`endif

/* tms_pkg.sv */
// types shared by the timer modulator serial block
package tms_pkg;
	typedef enum logic [1:0] {
		TMS_IDLE,
		TMS_SHIFT_LO,
		TMS_SHIFT_HI
	} tms_ser_state_t;

	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} tms_bus_req_t;

	typedef struct packed {
		logic sclk;
		logic sdo;
		logic out_a;
		logic out_b;
	} tms_pins_t;
endpackage : tms_pkg

/* tms_timer_assertions.sv */
// concurrent checks on the timer register port and serial pins
`timescale 1ns/100ps
module tms_timer_assertions (
	// clock and reset
	input wire logic                  clk_sys,
	input wire logic                  rst_n,
	// register port
	input wire tms_pkg::tms_bus_req_t bus_req,
	input wire logic [7:0]            bus_rdata,
	// outputs
	input wire tms_pkg::tms_pins_t    pins,
	input wire logic [7:0]            irq_flags
);
	// ==========================================================
	// shadow of serial mode and mask
	logic       en_q;
	logic       cpol_q;
	logic [5:0] mask_q;
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			en_q   <= 1'b0;
			cpol_q <= 1'b0;
		end else if (bus_req.wr && bus_req.addr == 4'h2) begin
			en_q   <= bus_req.wdata[1];
			cpol_q <= bus_req.wdata[0];
		end
	end
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			mask_q <= 6'h00;
		end else if (bus_req.wr && bus_req.addr == 4'h9) begin
			mask_q <= bus_req.wdata[5:0];
		end
	end
	// ==========================================================
	// properties
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	sequence s_rd(logic [3:0] a);
		bus_req.rd && bus_req.addr == a;
	endsequence
	sequence s_port_off;
		!en_q && $stable(en_q) && $stable(cpol_q);
	endsequence
	a_outb_inverse: assert property (pins.out_b == !pins.out_a)
		else $error("out_b not inverse of out_a");
	a_rdata_idle: assert property (!bus_req.rd |=> bus_rdata == 8'h00)
		else $error("read data outside read slot");
	a_unmapped_zero: assert property (
		bus_req.rd && bus_req.addr > 4'hc |=> bus_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_ctrl_b_zero: assert property (
		s_rd(4'h1) |=> bus_rdata[7:1] == 7'h00)
		else $error("control b upper bits not zero");
	a_ctrl_a_fixed: assert property (s_rd(4'h0) |=>
		bus_rdata[4] == 1'b0 && bus_rdata[2] == 1'b0)
		else $error("control a bit4 or bit2 not zero");
	a_sclk_idle: assert property (s_port_off |-> pins.sclk == cpol_q)
		else $error("shift clock not idle");
	a_sclk_half_rate: assert property (en_q && $past(en_q) &&
		$changed(pins.sclk) |=> $stable(pins.sclk))
		else $error("shift clock too fast");
	a_tx_empty_drop: assert property (
		bus_req.wr && bus_req.addr == 4'h3 && mask_q[4] |=> !irq_flags[4])
		else $error("tx empty still set after data write");
	a_irq_masked: assert property (
		(irq_flags & ~{2'b00, mask_q}) == 8'h00)
		else $error("unmasked flag on irq output");
endmodule : tms_timer_assertions

bind tms_timer tms_timer_assertions u_chk (
	.clk_sys   (clk_sys),
	.rst_n     (rst_n),
	.bus_req   (bus_req),
	.bus_rdata (bus_rdata),
	.pins      (pins),
	.irq_flags (irq_flags)
);

/* tms_periph_model.sv */
// serial peripheral: replies 5a, 5b, ... and keeps the last byte seen
`timescale 1ns/100ps
module tms_periph_model (
	// clock and reset
	input wire logic               clk_sys,
	input wire logic               rst_n,
	// serial lines
	input wire tms_pkg::tms_pins_t pins,
	output logic                   sdi,
	// last byte received
	output logic [7:0]             got
);
	logic [7:0] tx_sh;
	logic [7:0] rx_sh;
	logic [7:0] n_fr;
	logic [2:0] n_bit;
	logic       sclk_q;
	assign sdi = tx_sh[7];
	always_ff @(posedge clk_sys) begin
		sclk_q <= pins.sclk;
		if (!rst_n) begin
			tx_sh <= 8'h5a;
			n_fr  <= 8'h5a;
			n_bit <= 3'h0;
			got   <= 8'h00;
		end else if (pins.sclk && !sclk_q) begin
			rx_sh <= {rx_sh[6:0], pins.sdo};
		end else if (!pins.sclk && sclk_q) begin
			n_bit <= n_bit + 3'h1;
			tx_sh <= {tx_sh[6:0], 1'b0};
			if (n_bit == 3'h7) begin
				got   <= rx_sh;
				tx_sh <= n_fr + 8'h01;
				n_fr  <= n_fr + 8'h01;
			end
		end
	end
endmodule : tms_periph_model

/* tms_timer_tb_top.sv */
// self-checking bench for the timer modulator serial block
`timescale 1ns/100ps
module tms_timer_tb_top;
	logic                  clk_sys;
	logic                  rst_n;
	logic                  cin;
	logic                  run;
	logic                  cap_pin;
	logic                  oth_clk;
	logic                  sdi;
	logic                  stage_clk;
	logic [7:0]            rdata;
	logic [7:0]            irq;
	logic [7:0]            got;
	logic [7:0]            rv;
	logic [15:0]           w;
	tms_pkg::tms_bus_req_t req;
	tms_pkg::tms_pins_t    pins;
	int                    fails;
	int                    n_compared;
	// ==========================================================
	// instances
	tms_timer u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .bus_req(req),
		.bus_rdata(rdata), .counter_input_clock(cin),
		.capture_input_pin(cap_pin), .other_timer_out_clk(oth_clk),
		.sdi(sdi), .pins(pins), .counter_stage_out_clk(stage_clk),
		.irq_flags(irq));
	tms_periph_model u_peer (.clk_sys(clk_sys), .rst_n(rst_n),
		.pins(pins), .sdi(sdi), .got(got));
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) cin <= run ? ~cin : 1'b0;
	// ==========================================================
	// helpers
	task test_done;
		if (fails == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : test_done
	task chk(input logic [15:0] g, input logic [15:0] e);
		n_compared++;
		if (g !== e) begin
			fails++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		req <= '{a, d, 1'b1, 1'b0};
		@(posedge clk_sys);
		req.wr <= 1'b0;
	endtask : wr
	task rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		req <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk_sys);
		req.rd <= 1'b0;
		#1 d = rdata;
	endtask : rd
	task rd16(input logic [3:0] a, output logic [15:0] v);
		rd(a, v[7:0]);
		rd(a + 4'h1, v[15:8]);
	endtask : rd16
	task tick(input int n);
		run <= 1'b1;
		repeat (2 * n) @(posedge clk_sys);
		run <= 1'b0;
	endtask : tick
	task pulse(input logic p);
		@(posedge clk_sys);
		if (p)
			cap_pin <= 1'b1;
		else
			oth_clk <= 1'b1;
		repeat (3) @(posedge clk_sys);
		cap_pin <= 1'b0;
		oth_clk <= 1'b0;
		repeat (3) @(posedge clk_sys);
	endtask : pulse
	task pa(input logic e);
		repeat (3) @(posedge clk_sys);
		chk({15'h0000, pins.out_a}, {15'h0000, e});
	endtask : pa
	task wait_flag(input int b);
		int i;
		for (i = 0; i < 300; i++) begin
			rd(4'h8, rv);
			if (rv[b] === 1'b1)
				break;
		end
	endtask : wait_flag
	// ==========================================================
	// scenarios
	task t_reset;
		int a;
		for (a = 0; a < 16; a++) begin
			rd(a[3:0], rv);
			chk({8'h00, rv}, {8'h00, a == 8 ? 8'h10 : 8'h00});
		end
	endtask : t_reset
	task t_toggle;
		wr(4'h2, 8'h04);
		pa(1'b1);
		wr(4'h0, 8'hc0);
		pa(1'b0);
		wr(4'h2, 8'h04);
		pa(1'b0);
		wr(4'h0, 8'h00);
		wr(4'h0, 8'h80);
		pa(1'b0);
	endtask : t_toggle
	task t_count;
		wr(4'h7, 8'h12);
		wr(4'h6, 8'h34);
		rd16(4'h6, w);
		chk(w, 16'h1234);
		wr(4'h0, 8'h84);
		tick(10);
		rd16(4'hb, w);
		chk(w, 16'h000a);
		wr(4'h1, 8'h01);
		rd16(4'h4, w);
		chk(w, 16'h000a);
		rd(4'h1, rv);
		chk({8'h00, rv}, 16'h0000);
		wr(4'h0, 8'ha0);
		tick(5);
		pulse(1'b1);
		rd16(4'h4, w);
		chk(w, 16'h000f);
		wr(4'h0, 8'h80);
		tick(5);
		pulse(1'b1);
		rd16(4'h4, w);
		chk(w, 16'h000f);
		pulse(1'b0);
		rd16(4'h4, w);
		chk(w, 16'h0014);
		wr(4'h7, 8'h00);
		wr(4'h6, 8'h03);
		wr(4'h0, 8'h8c);
		tick(10);
		rd16(4'hb, w);
		chk({15'h0000, w < 16'h0004}, 16'h0001);
		wr(4'h0, 8'h84);
		wr(4'ha, 8'h40);
		wr(4'h8, 8'h3f);
		tick(200);
		rd(4'h8, rv);
		chk({15'h0000, rv[0]}, 16'h0000);
		tick(100);
		rd(4'h8, rv);
		chk({15'h0000, rv[0]}, 16'h0001);
		wr(4'ha, 8'h00);
		wr(4'h0, 8'h86);
		rv[1:0] = {stage_clk, pins.out_a};
		tick(4);
		pa(~rv[0]);
		chk({15'h0000, stage_clk}, {15'h0000, ~rv[1]});
	endtask : t_count
	task t_serial;
		wr(4'h9, 8'h3f);
		wr(4'h6, 8'h01);
		wr(4'h0, 8'h8c);
		wr(4'h3, 8'h3c);
		run <= 1'b1;
		repeat (40) @(posedge clk_sys);
		rd(4'h8, rv);
		chk({15'h0000, rv[4]}, 16'h0000);
		wr(4'h2, 8'h02);
		wait_flag(4);
		wr(4'h3, 8'hc3);
		wait_flag(5);
		chk({8'h00, rv & 8'h38}, 16'h0038);
		chk({8'h00, got}, 16'h00c3);
		rd(4'h3, rv);
		chk({8'h00, rv}, 16'h005b);
		run <= 1'b0;
		wr(4'h2, 8'h01);
		repeat (3) @(posedge clk_sys);
		chk({15'h0000, pins.sclk}, 16'h0001);
		wr(4'h8, 8'h20);
		rd(4'h8, rv);
		chk({8'h00, rv & 8'h28}, 16'h0000);
	endtask : t_serial
	// ==========================================================
	// main sequence and watchdog
	initial begin
		rst_n = 1'b0;
		req = '0;
		run = 1'b0;
		cin = 1'b0;
		cap_pin = 1'b0;
		oth_clk = 1'b0;
		fails = 0;
		n_compared = 0;
		repeat (16) @(posedge clk_sys);
		rst_n <= 1'b1;
		t_reset();
		t_toggle();
		t_count();
		t_serial();
		test_done();
	end
	initial begin
		#300000;
		fails++;
		test_done();
	end
endmodule : tms_timer_tb_top
